// file: rstint_pkg.sv
// constants, register map and carrier types of the reset and interrupt expansion block
package rstint_pkg;
   localparam int NUM_LINES = 6;
   localparam int NUM_SRC = 32;
   // register byte offsets
   localparam logic [7:0] OFS_PEND_LO = 8'h00;
   localparam logic [7:0] OFS_PEND_HI = 8'h04;
   localparam logic [7:0] OFS_EN_LO = 8'h08;
   localparam logic [7:0] OFS_EN_HI = 8'h0c;
   localparam logic [7:0] OFS_LINE_MASK = 8'h10;
   localparam logic [7:0] OFS_CTRL = 8'h14;
   localparam logic [7:0] OFS_SOFT = 8'h18;
   localparam logic [7:0] OFS_VEC = 8'h1c;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h20;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
   // control register fields
   localparam int CTRL_GID_BIT = 0;
   localparam int CTRL_SERLO_BIT = 1;
   // soft instruction register fields
   localparam int SOFT_KIND_LSB = 8;
   localparam logic [1:0] KIND_SOFT_IRQ_INSTR = 2'h1;
   localparam logic [1:0] KIND_NMI = 2'h2;
   localparam logic [1:0] KIND_TRAP = 2'h3;
   localparam logic [7:0] VEC_RESET = 8'h00;
   localparam logic [7:0] VEC_TRAP = 8'h22;
   localparam logic [7:0] VEC_NMI = 8'h24;
   localparam logic [7:0] VEC_EMU = 8'h26;
   // source bit positions: group 0 in [15:0], group 1 in [31:16]
   localparam int SRC_PWR = 0;
   localparam int SRC_ADC = 1;
   localparam int SRC_EXTA = 2;
   localparam int SRC_EXTB = 3;
   localparam int SRC_RX_HI = 5;
   localparam int SRC_TX_HI = 6;
   localparam int SRC_CAP = 20;
   localparam int SRC_RX_LO = 24;
   localparam int SRC_TX_LO = 25;
   // group membership of each core line, line one at index 0
   localparam logic [NUM_LINES-1:0][31:0] LINE_MEMBERS = {
      32'h0000_0000, 32'h0300_0000, 32'h0010_0000,
      32'h0000_0000, 32'h0000_0000, 32'h0000_006f};
   // interrupt status events
   localparam int EV_PIN_RST = 0;
   localparam int EV_WD_RST = 1;
   localparam int EV_SOFT = 2;
   localparam int EV_ACK = 3;
   localparam int NUM_EV = 4;
   localparam logic [31:0] RST_ZERO = 32'h0000_0000;
   localparam logic [15:0] CODE_NONE = 16'h0000;
   localparam logic [NUM_LINES-1:0] LINES_OFF = 6'h00;

   // source vector code for each pending bit
   function automatic logic [15:0] code_of(input logic [4:0] idx);
      logic [15:0] c;
      c = CODE_NONE;
      case (idx)
         5'h00: c = 16'h0020;
         5'h01: c = 16'h0004;
         5'h02: c = 16'h0001;
         5'h03: c = 16'h0011;
         5'h05: c = 16'h0006;
         5'h06: c = 16'h0007;
         5'h14: c = 16'h0033;
         5'h18: c = 16'h0006;
         5'h19: c = 16'h0007;
         default: c = CODE_NONE;
      endcase
      return c;
   endfunction

   typedef struct packed {
      logic valid;
      logic [2:0] line;
   } rstint_ack_t;

   typedef struct packed {
      logic valid;
      logic [7:0] vector;
   } rstint_branch_t;
endpackage

// file: rstint_prio.sv
// lowest-index-first priority pick over the candidate source bits
`timescale 1ns/1ps
module rstint_prio (
   input wire logic [31:0] cand,
   output logic found,
   output logic [4:0] idx
);
   logic [31:0] hit;
   // one-hot of the first set bit, bit 0 wins
   genvar g;
   generate
      for (g = 0; g < 32; g++) begin : g_hit
         if (g == 0) begin : g_first
            assign hit[g] = cand[g];
         end else begin : g_rest
            assign hit[g] = cand[g] & ~(|cand[g-1:0]);
         end
      end
   endgenerate
   // encode the one-hot
   always_comb begin
      idx = 5'h00;
      for (int i = 0; i < 32; i++) begin
         if (hit[i]) begin
            idx = 5'(i);
         end
      end
   end
   assign found = |cand;
endmodule

// file: rstint_top.sv
// reset and interrupt expansion block with APB register access
//
// The implementer's own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module rstint_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic rst_pin_n,
   input wire logic wdog_timeout,
   input wire logic power_protect_irq,
   input wire logic ext_irq_a,
   input wire logic ext_irq_b,
   input wire logic converter_irq,
   input wire logic serial_rx_irq,
   input wire logic serial_tx_irq,
   input wire logic capture_irq,
   input rstint_pkg::rstint_ack_t core_ack,
   output logic [rstint_pkg::NUM_LINES-1:0] core_line,
   output logic [15:0] source_vector_code,
   output rstint_pkg::rstint_branch_t branch,
   output logic sys_reset,
   output logic global_irq_disable,
   output logic irq
);
   import rstint_pkg::*;

   logic [31:0] pend_q, en_q;
   logic [NUM_LINES-1:0] core_line_mask_q, line_q;
   logic gid_q, serlo_q, rst_q, irq_q, pready_q, pslverr_q;
   logic [31:0] prdata_q;
   logic [15:0] code_q;
   rstint_branch_t branch_q;
   logic [NUM_EV-1:0] ev_stat_q, ev_mask_q, ev_set;
   logic [31:0] req, cand, ack_clr;
   logic rst_src, wr, rd_setup, mapped, ack_found;
   logic [4:0] ack_idx;
   logic [1:0] soft_kind;

   // either reset source gives the same reset
   assign rst_src = ~rst_pin_n | wdog_timeout;

   // bus strobes: write lands on the access edge where pready is seen
   assign wr = psel & penable & pwrite & pready_q & mapped;
   assign rd_setup = psel & ~penable;
   assign soft_kind = pwdata[SOFT_KIND_LSB +: 2];
   always_comb begin
      mapped = 1'b1;
      unique case (paddr[7:0])
         OFS_PEND_LO, OFS_PEND_HI, OFS_EN_LO, OFS_EN_HI, OFS_LINE_MASK,
         OFS_CTRL, OFS_SOFT, OFS_VEC, OFS_IRQ_STAT, OFS_IRQ_MASK: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
      if (paddr[31:8] != 24'h000000) begin
         mapped = 1'b0;
      end
   end

   // route requests; serial lands in group 0 or group 1 by mode
   always_comb begin
      req = RST_ZERO;
      req[SRC_PWR] = power_protect_irq;
      req[SRC_ADC] = converter_irq;
      req[SRC_EXTA] = ext_irq_a;
      req[SRC_EXTB] = ext_irq_b;
      req[SRC_RX_HI] = serial_rx_irq & ~serlo_q;
      req[SRC_TX_HI] = serial_tx_irq & ~serlo_q;
      req[SRC_RX_LO] = serial_rx_irq & serlo_q;
      req[SRC_TX_LO] = serial_tx_irq & serlo_q;
      req[SRC_CAP] = capture_irq;
   end

   // candidates of the acknowledged line's group; a line past the last selects none
   assign cand = (core_ack.line < 3'(NUM_LINES)) ? (pend_q & en_q & LINE_MEMBERS[core_ack.line])
                 : RST_ZERO;
   rstint_prio u_prio (
      .cand(cand),
      .found(ack_found),
      .idx(ack_idx)
   );
   assign ack_clr = (core_ack.valid && core_ack.line < 3'(NUM_LINES) && ack_found) ?
                    (32'h0000_0001 << ack_idx) : RST_ZERO;

   // pending flags: request sets, ack or write-one clears, set wins
   genvar b;
   generate
      for (b = 0; b < NUM_SRC; b++) begin : g_pend
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pend_q[b] <= 1'b0;
            end else if (rst_src) begin
               pend_q[b] <= 1'b0;
            end else if (req[b]) begin
               pend_q[b] <= 1'b1;
            end else if (ack_clr[b]) begin
               pend_q[b] <= 1'b0;
            end else if (wr && ((b < 16 && paddr[7:0] == OFS_PEND_LO && pwdata[b % 16]) ||
                                (b >= 16 && paddr[7:0] == OFS_PEND_HI && pwdata[b % 16]))) begin
               pend_q[b] <= 1'b0;
            end
         end
      end
   endgenerate

   // source enables and core line mask: all off after any reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         en_q <= RST_ZERO;
         core_line_mask_q <= LINES_OFF;
      end else if (rst_src) begin
         en_q <= RST_ZERO;
         core_line_mask_q <= LINES_OFF;
      end else if (wr) begin
         if (paddr[7:0] == OFS_EN_LO) begin
            en_q[15:0] <= pwdata[15:0];
         end
         if (paddr[7:0] == OFS_EN_HI) begin
            en_q[31:16] <= pwdata[15:0];
         end
         if (paddr[7:0] == OFS_LINE_MASK) begin
            core_line_mask_q <= pwdata[NUM_LINES-1:0];
         end
      end
   end

   // control bits and soft instructions
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gid_q <= 1'b1;
         serlo_q <= 1'b0;
         branch_q <= '0;
      end else if (rst_src) begin
         gid_q <= 1'b1;
         serlo_q <= 1'b0;
         branch_q <= '0;
      end else begin
         branch_q.valid <= 1'b0;
         if (wr && paddr[7:0] == OFS_CTRL) begin
            gid_q <= pwdata[CTRL_GID_BIT];
            serlo_q <= pwdata[CTRL_SERLO_BIT];
         end
         if (wr && paddr[7:0] == OFS_SOFT) begin
            unique case (soft_kind)
               KIND_SOFT_IRQ_INSTR: begin
                  branch_q.valid <= 1'b1;
                  branch_q.vector <= pwdata[7:0];
                  gid_q <= 1'b1;
               end
               KIND_NMI: begin
                  branch_q.valid <= 1'b1;
                  branch_q.vector <= VEC_NMI;
                  gid_q <= 1'b1;
               end
               KIND_TRAP: begin
                  branch_q.valid <= 1'b1;
                  branch_q.vector <= VEC_TRAP;
               end
               default: branch_q.valid <= 1'b0;
            endcase
         end
      end
   end

   // core lines: group has a pending, enabled, unmasked source
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_q <= LINES_OFF;
      end else if (rst_src) begin
         line_q <= LINES_OFF;
      end else begin
         for (int l = 0; l < NUM_LINES; l++) begin
            line_q[l] <= |(pend_q & en_q & LINE_MEMBERS[l]) & core_line_mask_q[l];
         end
      end
   end

   // vector code presented on acknowledge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         code_q <= CODE_NONE;
      end else if (rst_src) begin
         code_q <= CODE_NONE;
      end else if (core_ack.valid) begin
         code_q <= ack_found ? code_of(ack_idx) : CODE_NONE;
      end
   end

   // reset output: follows the sources one clock later, vector 0000h outside arbitration
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rst_q <= 1'b1;
      end else begin
         rst_q <= rst_src;
      end
   end

   // sticky events, write one to clear, set wins
   always_comb begin
      ev_set = '0;
      ev_set[EV_PIN_RST] = ~rst_pin_n;
      ev_set[EV_WD_RST] = wdog_timeout;
      ev_set[EV_SOFT] = branch_q.valid;
      ev_set[EV_ACK] = core_ack.valid & ack_found;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ev_stat_q <= '0;
         ev_mask_q <= '0;
      end else begin
         if (wr && paddr[7:0] == OFS_IRQ_STAT) begin
            ev_stat_q <= (ev_stat_q & ~pwdata[NUM_EV-1:0]) | ev_set;
         end else begin
            ev_stat_q <= ev_stat_q | ev_set;
         end
         if (wr && paddr[7:0] == OFS_IRQ_MASK) begin
            ev_mask_q <= pwdata[NUM_EV-1:0];
         end
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(ev_stat_q & ev_mask_q);
      end
   end

   // apb answer: no wait states, data captured in setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= RST_ZERO;
      end else begin
         pready_q <= rd_setup;
         pslverr_q <= rd_setup & ~mapped;
         if (rd_setup) begin
            prdata_q <= RST_ZERO;
            unique case (paddr[7:0])
               OFS_PEND_LO: prdata_q[15:0] <= pend_q[15:0];
               OFS_PEND_HI: prdata_q[15:0] <= pend_q[31:16];
               OFS_EN_LO: prdata_q[15:0] <= en_q[15:0];
               OFS_EN_HI: prdata_q[15:0] <= en_q[31:16];
               OFS_LINE_MASK: prdata_q[NUM_LINES-1:0] <= core_line_mask_q;
               OFS_CTRL: prdata_q[1:0] <= {serlo_q, gid_q};
               OFS_VEC: prdata_q[15:0] <= code_q;
               OFS_IRQ_STAT: prdata_q[NUM_EV-1:0] <= ev_stat_q;
               OFS_IRQ_MASK: prdata_q[NUM_EV-1:0] <= ev_mask_q;
               default: prdata_q <= RST_ZERO;
            endcase
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign core_line = line_q;
   assign source_vector_code = code_q;
   assign branch = branch_q;
   assign sys_reset = rst_q;
   assign global_irq_disable = gid_q;
   assign irq = irq_q;

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   chk_reset_now: assert property (rst_src |=> sys_reset && core_line == LINES_OFF)
      else $error("reset did not act at once");
   chk_reset_disables: assert property (rst_src |=> en_q == RST_ZERO && gid_q)
      else $error("interrupts still enabled after reset");
   chk_wdog_reset: assert property (wdog_timeout |=> sys_reset)
      else $error("watchdog time-out gave no reset");
   chk_soft_irq_instr_branch: assert property (wr && paddr[7:0] == OFS_SOFT && soft_kind == KIND_SOFT_IRQ_INSTR
      && !rst_src |=> branch.valid && branch.vector == $past(pwdata[7:0]) && gid_q)
      else $error("soft interrupt branch wrong");
   chk_nmi_branch: assert property (wr && paddr[7:0] == OFS_SOFT && soft_kind == KIND_NMI
      && !rst_src |=> branch.valid && branch.vector == VEC_NMI && gid_q)
      else $error("nmi branch wrong");
   chk_trap_keeps: assert property (wr && paddr[7:0] == OFS_SOFT && soft_kind == KIND_TRAP
      && !rst_src |=> branch.vector == VEC_TRAP && gid_q == $past(gid_q))
      else $error("trap changed global disable");
   chk_line_cause: assert property (core_line[0] |-> $past(|(pend_q & en_q & LINE_MEMBERS[0])
      && core_line_mask_q[0]))
      else $error("line one high with no source");
   chk_pwr_line: assert property (power_protect_irq && en_q[0] && core_line_mask_q[0]
      && !rst_src ##1 !rst_src |=> core_line[0])
      else $error("power protect request missed line one");
   chk_cap_code: assert property (core_ack.valid && cand[SRC_CAP] && !rst_src
      |=> source_vector_code == 16'h0033 && (!pend_q[SRC_CAP] || $past(capture_irq)))
      else $error("capture ack code wrong");
   chk_rx_low: assert property (serial_rx_irq && serlo_q && !rst_src |=> pend_q[SRC_RX_LO]
      && !pend_q[SRC_RX_HI] || $past(pend_q[SRC_RX_HI]))
      else $error("serial receive in wrong group");
   cov_nmi: cover property (branch.valid && branch.vector == VEC_NMI);
   cov_ack: cover property (core_ack.valid && ack_found);
   cov_wd: cover property (wdog_timeout ##1 sys_reset);
   cov_irq: cover property (irq);
endmodule

// file: rstint_core_model.sv
// behavioural processor core that acknowledges the six core interrupt lines
`timescale 1ns/1ps
module rstint_core_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [rstint_pkg::NUM_LINES-1:0] core_line,
   input wire logic ack_en,
   input wire logic [3:0] ack_wait,
   output rstint_pkg::rstint_ack_t core_ack
);
   import rstint_pkg::*;
   logic [3:0] wait_q;
   logic [2:0] hold_q;
   logic [2:0] first_d;
   rstint_ack_t ack_q;

   // lowest numbered raised line is served first
   always_comb begin
      first_d = 3'h0;
      for (int i = NUM_LINES - 1; i >= 0; i--) begin
         if (core_line[i]) begin
            first_d = 3'(i);
         end
      end
   end

   // wait ack_wait cycles, pulse one acknowledge, then hold off while the line settles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wait_q <= 4'h0;
         hold_q <= 3'h0;
         ack_q <= '0;
      end else begin
         ack_q.valid <= 1'b0;
         if (hold_q != 3'h0) begin
            hold_q <= hold_q - 3'h1;
         end else if (ack_en && core_line != LINES_OFF) begin
            if (wait_q < ack_wait) begin
               wait_q <= wait_q + 4'h1;
            end else begin
               wait_q <= 4'h0;
               ack_q.valid <= 1'b1;
               ack_q.line <= first_d;
               hold_q <= 3'h4;
            end
         end else begin
            wait_q <= 4'h0;
         end
      end
   end
   assign core_ack = ack_q;
endmodule

// file: reset_and_interrupt_expansion_tb.sv
// self-checking bench for the reset and interrupt expansion block
`timescale 1ns/1ps
module reset_and_interrupt_expansion_tb;
   import rstint_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic rst_pin_n, wdog_timeout, sys_reset, gid, irq, ack_en;
   logic [6:0] req;
   logic [3:0] ack_wait;
   logic [5:0] core_line;
   logic [15:0] code;
   rstint_ack_t core_ack;
   rstint_branch_t branch;
   int fail_count, total_checks;

   rstint_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .rst_pin_n(rst_pin_n), .wdog_timeout(wdog_timeout),
      .power_protect_irq(req[0]), .converter_irq(req[1]), .ext_irq_a(req[2]),
      .ext_irq_b(req[3]), .serial_rx_irq(req[4]), .serial_tx_irq(req[5]),
      .capture_irq(req[6]), .core_ack(core_ack), .core_line(core_line),
      .source_vector_code(code), .branch(branch), .sys_reset(sys_reset),
      .global_irq_disable(gid), .irq(irq));
   rstint_core_model core_model (.pclk(pclk), .presetn(presetn), .core_line(core_line),
      .ack_en(ack_en), .ack_wait(ack_wait), .core_ack(core_ack));

   // clock
   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   task automatic report_and_stop();
      if (fail_count == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   // one apb transfer: setup, access held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {24'h0, a}; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      if (n == 20) fail_count++;
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, msg);
   endtask

   task automatic pulse(input int i);
      @(posedge pclk) req[i] <= 1'b1;
      @(posedge pclk) req[i] <= 1'b0;
   endtask

   task automatic wait_line(input int i, input logic v);
      int n;
      n = 0;
      while (core_line[i] !== v && n < 12) begin
         @(posedge pclk);
         n++;
      end
      chk(core_line[i], v, "core line level");
   endtask

   // let the core model acknowledge once, then judge the line and the code
   task automatic ack_check(input logic [2:0] ln, input logic [15:0] exp);
      int n;
      n = 0;
      ack_en <= 1'b1;
      while (core_ack.valid !== 1'b1 && n < 30) begin
         @(posedge pclk);
         n++;
      end
      ack_en <= 1'b0;
      chk(core_ack.valid, 1'b1, "acknowledge seen");
      chk(core_ack.line, ln, "acknowledged line");
      @(posedge pclk);
      chk(code, exp, "source vector code");
   endtask

   task automatic t_gate();
      apb(1'b1, OFS_LINE_MASK, 32'h1);
      pulse(SRC_PWR);
      repeat (3) @(posedge pclk);
      chk(core_line, 6'h00, "line while source disabled");
      rdc(OFS_PEND_LO, 32'h1, "pending after request");
      apb(1'b1, OFS_EN_LO, 32'h1);
      wait_line(0, 1'b1);
      apb(1'b1, OFS_LINE_MASK, 32'h0);
      repeat (3) @(posedge pclk);
      chk(core_line, 6'h00, "line while core masked");
      apb(1'b1, OFS_LINE_MASK, 32'h3f);
      ack_check(3'h0, 16'h0020);
      wait_line(0, 1'b0);
      rdc(OFS_PEND_LO, 32'h0, "pending cleared by ack");
   endtask

   task automatic t_prio();
      ack_wait <= 4'h0;
      apb(1'b1, OFS_EN_LO, 32'h6d);
      pulse(SRC_ADC);
      repeat (3) @(posedge pclk);
      chk(core_line, 6'h00, "converter without enable");
      apb(1'b1, OFS_PEND_LO, 32'h2);
      apb(1'b1, OFS_EN_LO, 32'h6f);
      pulse(SRC_EXTA);
      pulse(SRC_ADC);
      pulse(SRC_EXTB);
      ack_check(3'h0, 16'h0004);
      ack_check(3'h0, 16'h0001);
      ack_check(3'h0, 16'h0011);
      pulse(4);
      ack_check(3'h0, 16'h0006);
   endtask

   task automatic t_groups();
      ack_wait <= 4'h5;
      apb(1'b1, OFS_EN_HI, 32'h0310);
      pulse(6);
      wait_line(3, 1'b1);
      ack_check(3'h3, 16'h0033);
      apb(1'b1, OFS_CTRL, 32'h2);
      pulse(4);
      wait_line(4, 1'b1);
      chk(core_line[0], 1'b0, "rx off line one in low mode");
      ack_check(3'h4, 16'h0006);
   endtask

   task automatic t_soft();
      logic [9:0] op [4] = '{10'h126, 10'h102, 10'h200, 10'h355};
      logic [7:0] vec [4] = '{8'h26, 8'h02, 8'h24, 8'h22};
      logic g [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
      int n;
      for (int k = 0; k < 4; k++) begin
         apb(1'b1, OFS_CTRL, 32'h0);
         apb(1'b1, OFS_SOFT, {22'h0, op[k]});
         n = 0;
         while (branch.valid !== 1'b1 && n < 10) begin
            @(posedge pclk);
            n++;
         end
         chk(branch.valid, 1'b1, "branch pulse");
         chk(branch.vector, vec[k], "branch vector");
         chk(gid, g[k], "global disable after branch");
      end
      rdc(OFS_IRQ_STAT, 32'hc, "status after branches and acks");
      chk(irq, 1'b0, "irq masked");
      apb(1'b1, OFS_IRQ_MASK, 32'h4);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b1, "irq raised");
      apb(1'b1, OFS_IRQ_STAT, 32'h4);
      repeat (2) @(posedge pclk);
      chk(irq, 1'b0, "irq after clear");
      apb(1'b0, 8'h40, 32'h0);
      chk(err, 1'b1, "unmapped error");
      chk(rd, 32'h0, "unmapped read");
   endtask

   task automatic t_rst();
      for (int s = 0; s < 2; s++) begin
         apb(1'b1, OFS_IRQ_STAT, 32'hf);
         apb(1'b1, OFS_EN_LO, 32'h1);
         apb(1'b1, OFS_LINE_MASK, 32'h1);
         apb(1'b1, OFS_CTRL, 32'h0);
         pulse(SRC_PWR);
         wait_line(0, 1'b1);
         @(posedge pclk);
         if (s == 0) rst_pin_n <= 1'b0;
         else wdog_timeout <= 1'b1;
         @(posedge pclk);
         @(posedge pclk);
         chk(sys_reset, 1'b1, "reset output");
         chk(core_line, 6'h00, "lines dropped at reset");
         chk(gid, 1'b1, "disable set by reset");
         rst_pin_n <= 1'b1;
         wdog_timeout <= 1'b0;
         repeat (3) @(posedge pclk);
         chk(sys_reset, 1'b0, "reset released");
         rdc(OFS_EN_LO, 32'h0, "enables after reset");
         rdc(OFS_LINE_MASK, 32'h0, "line mask after reset");
         rdc(OFS_IRQ_STAT, 32'h1 << s, "reset cause");
      end
   endtask

   // main sequence
   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 32'h0;
      pwdata = 32'h0; rst_pin_n = 1'b1; wdog_timeout = 1'b0; req = 7'h00;
      ack_en = 1'b0; ack_wait = 4'h2; fail_count = 0; total_checks = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      chk({sys_reset, gid}, 2'b01, "state after power-up reset");
      rdc(OFS_VEC, 32'h0, "no vector code yet");
      t_gate();
      t_prio();
      t_groups();
      t_soft();
      t_rst();
      report_and_stop();
   end

   // watchdog against a hung handshake
   initial begin
      repeat (6000) @(posedge pclk);
      fail_count++;
      report_and_stop();
   end
endmodule
